// [core/dllk_pkg.sv]
package dllk_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // register map
  localparam logic [7:0] LML_OFFSET = 8'h04;
  localparam logic [7:0] LML_STATUS_OFFSET = 8'h08;

  ////////////////////////////////////////////////////////////////////////////////
  // lowmid_block_lock field layout
  localparam int LME_POS = 31;
  localparam int TEST_SHADOW_LOCK_POS = 20;
  localparam int MLK_POS = 16;
  localparam int MLK_WIDTH = 2;
  localparam int LLK_POS = 0;
  localparam int LLK_WIDTH = 16;

  // every lock field set, edit enable clear: the safe state before the load
  localparam logic [31:0] LML_RESET = 32'h0013FFFF;
  localparam logic [31:0] LML_PASSWORD = 32'hA1A11111;

  ////////////////////////////////////////////////////////////////////////////////
  // status register layout
  localparam int STAT_LOADED_POS = 0;
  localparam int STAT_INTERLOCK_POS = 1;
  localparam int STAT_SUSPENDED_POS = 2;
  localparam int STAT_BLOCKED_POS = 3;

  ////////////////////////////////////////////////////////////////////////////////
  // nonvolatile default word location in the test sector
  localparam logic [23:0] NV_DEFAULT_ADDR = 24'hC03DE8;

  typedef enum logic [2:0] {
    DLLK_LD_IDLE = 3'b001,
    DLLK_LD_REQ = 3'b010,
    DLLK_LD_DONE = 3'b100
  } dllk_ld_state_t;

endpackage

// [core/dllk_nv_loader.sv]
module dllk_nv_loader (
  input wire logic sys_clk,
  input wire logic arst_n,
  output logic nv_rd_req,
  output logic [23:0] nv_addr,
  input wire logic nv_rd_valid,
  input wire logic [31:0] nv_rd_data,
  output logic load_pulse,
  output logic [31:0] load_word,
  output logic loaded
);
  import dllk_pkg::*;

  dllk_ld_state_t state_reg;
  dllk_ld_state_t state_next;
  logic pulse_next;
  logic [31:0] word_next;

  ////////////////////////////////////////////////////////////////////////////////
  // one read of the default word right after reset release
  always_comb begin
    state_next = state_reg;
    pulse_next = 1'b0;
    word_next = load_word;
    case (state_reg)
      DLLK_LD_IDLE: state_next = DLLK_LD_REQ;
      DLLK_LD_REQ: begin
        if (nv_rd_valid) begin
          state_next = DLLK_LD_DONE;
          pulse_next = 1'b1;
          word_next = nv_rd_data;
        end
      end
      DLLK_LD_DONE: state_next = DLLK_LD_DONE;
      default: state_next = DLLK_LD_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= DLLK_LD_IDLE;
      load_pulse <= 1'b0;
      load_word <= 32'hFFFFFFFF;
      nv_rd_req <= 1'b0;
      nv_addr <= NV_DEFAULT_ADDR;
      loaded <= 1'b0;
    end else begin
      // fixed address, still kept in a flop so the top output is registered
      nv_addr <= NV_DEFAULT_ADDR;
      state_reg <= state_next;
      load_pulse <= pulse_next;
      load_word <= word_next;
      nv_rd_req <= (state_next == DLLK_LD_REQ);
      loaded <= (state_next == DLLK_LD_DONE);
    end
  end

endmodule

// [core/dllk_wb_slave.sv]
module dllk_wb_slave #(
  parameter int ADDR_W = 8
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic wb_ack_o,
  output logic [31:0] wb_dat_o,
  input wire logic ready,
  input wire logic [31:0] rdata,
  output logic wr_stb,
  output logic [ADDR_W-1:0] req_adr,
  output logic [31:0] wdata,
  output logic [3:0] wbe
);

  logic take;
  logic ack_next;
  logic [31:0] dat_next;

  assign req_adr = wb_adr_i;
  assign wdata = wb_dat_i;
  assign wbe = wb_sel_i;
  // held off until loaded, which rises with load_pulse, a cycle before the lock register holds the word; ack drops right after
  assign take = wb_cyc_i && wb_stb_i && ready && !wb_ack_o;
  assign wr_stb = take && wb_we_i;

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    ack_next = take;
    dat_next = wb_dat_o;
    if (take) begin
      dat_next = wb_we_i ? 32'h00000000 : rdata;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= ack_next;
      wb_dat_o <= dat_next;
    end
  end

endmodule

// [core/dllk_lock.sv]
// Local design decision: register access over Wishbone.
module dllk_lock #(
  parameter int ADDR_W = 8,
  parameter int LOW_SECTORS = 4,
  parameter int MID_SECTORS = 0
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic wb_ack_o,
  output logic [31:0] wb_dat_o,
  input wire logic secondary_test_shadow_lock,
  input wire logic [dllk_pkg::LLK_WIDTH-1:0] secondary_low_lock,
  input wire logic [dllk_pkg::MLK_WIDTH-1:0] secondary_mid_lock,
  input wire logic interlock_write,
  input wire logic done_flag,
  input wire logic erase_suspend_flag,
  output logic nv_rd_req,
  output logic [23:0] nv_addr,
  input wire logic nv_rd_valid,
  input wire logic [31:0] nv_rd_data,
  output logic lock_edit_enable,
  output logic test_shadow_prog_lock,
  output logic test_shadow_erase_lock,
  output logic [dllk_pkg::LLK_WIDTH-1:0] low_space_lock,
  output logic [dllk_pkg::MLK_WIDTH-1:0] mid_space_lock
);
  import dllk_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // parameter check

  generate
    if (LOW_SECTORS < 1 || LOW_SECTORS > LLK_WIDTH) begin : g_bad_low
      $error("LOW_SECTORS must lie in 1..16");
    end
    if (MID_SECTORS < 0 || MID_SECTORS > MLK_WIDTH) begin : g_bad_mid
      $error("MID_SECTORS must lie in 0..2");
    end
    if (ADDR_W < 4) begin : g_bad_adr
      $error("ADDR_W must be at least 4 to reach the status offset");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // decoding helpers

  function automatic logic [31:0] lane_mask(input logic [3:0] be);
    logic [31:0] m;
    m = 32'h00000000;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        m[i*8 +: 8] = 8'hFF;
      end
    end
    return m;
  endfunction

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
    return a == ADDR_W'(off);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // masks of present, writable lock bits

  logic [31:0] present_mask;
  logic [31:0] frozen_mask;

  generate
    for (genvar i = 0; i < LLK_WIDTH; i++) begin : g_low_mask
      assign present_mask[LLK_POS+i] = (i < LOW_SECTORS);
      assign frozen_mask[LLK_POS+i] = 1'b1;
    end
    // mid locks are not frozen: only test/shadow and low locks are
    for (genvar i = 0; i < MLK_WIDTH; i++) begin : g_mid_mask
      assign present_mask[MLK_POS+i] = (i < MID_SECTORS);
      assign frozen_mask[MLK_POS+i] = 1'b0;
    end
    for (genvar i = MLK_POS + MLK_WIDTH; i < 32; i++) begin : g_hi_mask
      assign present_mask[i] = (i == TEST_SHADOW_LOCK_POS);
      assign frozen_mask[i] = (i == TEST_SHADOW_LOCK_POS);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // submodules

  logic loaded;
  logic load_pulse;
  logic [31:0] load_word;
  logic wr_stb;
  logic [ADDR_W-1:0] req_adr;
  logic [31:0] wdata;
  logic [3:0] wbe;
  logic [31:0] rdata;

  dllk_nv_loader u_loader (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .nv_rd_req(nv_rd_req),
    .nv_addr(nv_addr),
    .nv_rd_valid(nv_rd_valid),
    .nv_rd_data(nv_rd_data),
    .load_pulse(load_pulse),
    .load_word(load_word),
    .loaded(loaded)
  );

  dllk_wb_slave #(
    .ADDR_W(ADDR_W)
  ) u_slave (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i),
    .wb_sel_i(wb_sel_i),
    .wb_ack_o(wb_ack_o),
    .wb_dat_o(wb_dat_o),
    .ready(loaded),
    .rdata(rdata),
    .wr_stb(wr_stb),
    .req_adr(req_adr),
    .wdata(wdata),
    .wbe(wbe)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // high-voltage sequence tracking

  logic interlock_reg;
  logic interlock_next;
  logic done_q_reg;
  logic done_rise;
  logic suspended;
  logic hv_blocked;

  assign done_rise = done_flag && !done_q_reg;
  // no flop here: a write in the first suspended cycle is refused too
  assign suspended = erase_suspend_flag && done_flag;
  assign hv_blocked = interlock_reg || suspended;

  always_comb begin
    interlock_next = interlock_reg;
    if (done_rise) begin
      interlock_next = 1'b0;
    end
    // a new interlock write beats a done edge in the same cycle
    if (interlock_write) begin
      interlock_next = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      interlock_reg <= 1'b0;
      done_q_reg <= 1'b0;
    end else begin
      interlock_reg <= interlock_next;
      done_q_reg <= done_flag;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // lock register

  logic [31:0] lock_reg;
  logic [31:0] lock_next;
  logic lme_reg;
  logic lme_next;
  logic lml_wr;
  logic [31:0] wr_mask;
  logic pw_match;

  assign lml_wr = wr_stb && hit(req_adr, LML_OFFSET);
  assign pw_match = (wdata == LML_PASSWORD) && (wbe == 4'hF);

  always_comb begin
    lock_next = lock_reg;
    lme_next = lme_reg;
    wr_mask = present_mask & lane_mask(wbe);
    if (hv_blocked) begin
      wr_mask = wr_mask & ~frozen_mask;
    end
    if (load_pulse) begin
      // absent sectors stay locked whatever the word holds; erased word is all ones
      lock_next = (load_word & present_mask) | (LML_RESET & ~present_mask);
    end else if (lml_wr) begin
      if (!lme_reg) begin
        // only a full-word password opens editing; anything else is dropped
        if (pw_match) begin
          lme_next = 1'b1;
        end
      end else begin
        lock_next = (lock_reg & ~wr_mask) | (wdata & wr_mask);
      end
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      lock_reg <= LML_RESET;
      lme_reg <= 1'b0;
    end else begin
      lock_reg <= lock_next;
      lme_reg <= lme_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // read data

  logic [31:0] lml_view;
  logic [31:0] status_view;

  always_comb begin
    lml_view = lock_reg & LML_RESET;
    lml_view[LME_POS] = lme_reg;
    status_view = 32'h00000000;
    status_view[STAT_LOADED_POS] = loaded;
    status_view[STAT_INTERLOCK_POS] = interlock_reg;
    status_view[STAT_SUSPENDED_POS] = suspended;
    status_view[STAT_BLOCKED_POS] = hv_blocked;
    rdata = 32'h00000000;
    if (hit(req_adr, LML_OFFSET)) begin
      rdata = lml_view;
    end else if (hit(req_adr, LML_STATUS_OFFSET)) begin
      rdata = status_view;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // effective locks, registered so the sequencer sees clean levels

  logic [LLK_WIDTH-1:0] low_comb;
  logic [MLK_WIDTH-1:0] mid_comb;
  logic ts_comb;

  generate
    for (genvar i = 0; i < LLK_WIDTH; i++) begin : g_low_eff
      assign low_comb[i] = lock_reg[LLK_POS+i] | secondary_low_lock[i];
    end
    for (genvar i = 0; i < MLK_WIDTH; i++) begin : g_mid_eff
      assign mid_comb[i] = lock_reg[MLK_POS+i] | secondary_mid_lock[i];
    end
  endgenerate

  assign ts_comb = lock_reg[TEST_SHADOW_LOCK_POS] | secondary_test_shadow_lock;

  ////////////////////////////////////////////////////////////////////////////////
  // output stage: every top-level lock output has its own flop

  logic ts_prog_next;
  logic ts_erase_next;
  logic [LLK_WIDTH-1:0] low_out_next;
  logic [MLK_WIDTH-1:0] mid_out_next;
  logic lme_out_next;

  always_comb begin
    ts_prog_next = ts_comb;
    // erase of the test block has no unlock path at all
    ts_erase_next = 1'b1;
    low_out_next = low_comb;
    mid_out_next = mid_comb;
    lme_out_next = lme_reg;
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      test_shadow_prog_lock <= 1'b1;
      test_shadow_erase_lock <= 1'b1;
      low_space_lock <= {LLK_WIDTH{1'b1}};
      mid_space_lock <= {MLK_WIDTH{1'b1}};
      lock_edit_enable <= 1'b0;
    end else begin
      test_shadow_prog_lock <= ts_prog_next;
      test_shadow_erase_lock <= ts_erase_next;
      low_space_lock <= low_out_next;
      mid_space_lock <= mid_out_next;
      lock_edit_enable <= lme_out_next;
    end
  end

endmodule

// [bench/dllk_lock_sva.sv]
module dllk_lock_chk #(
  parameter int ADDR_W = 8,
  parameter int LOW_SECTORS = 4,
  parameter int MID_SECTORS = 0
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  input wire logic secondary_test_shadow_lock,
  input wire logic [dllk_pkg::LLK_WIDTH-1:0] secondary_low_lock,
  input wire logic nv_rd_req,
  input wire logic [23:0] nv_addr,
  input wire logic nv_rd_valid,
  input wire logic lock_edit_enable,
  input wire logic test_shadow_prog_lock,
  input wire logic test_shadow_erase_lock,
  input wire logic [dllk_pkg::LLK_WIDTH-1:0] low_space_lock,
  input wire logic [dllk_pkg::MLK_WIDTH-1:0] mid_space_lock
);
  import dllk_pkg::*;
  // absent sectors sit above the present count
  localparam logic [15:0] LOW_ABS = ~((16'h0001 << LOW_SECTORS) - 16'h0001);
  localparam logic [1:0] MID_ABS = ~((2'h1 << MID_SECTORS) - 2'h1);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  ////////////////////////////////////////
  ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  ack_has_req_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  unmapped_zero_a: assert property (wb_ack_o && !$past(wb_we_i) &&
    $past(wb_adr_i) != LML_OFFSET && $past(wb_adr_i) != LML_STATUS_OFFSET |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  edit_sticky_a: assert property (lock_edit_enable |=> lock_edit_enable)
    else $error("edit enable dropped");
  edit_password_a: assert property ($rose(lock_edit_enable) |->
    $past(wb_we_i && wb_dat_i == LML_PASSWORD && wb_sel_i == 4'hF))
    else $error("edit enable without password");
  erase_lock_a: assert property (test_shadow_erase_lock)
    else $error("test block erase allowed");
  absent_locked_a: assert property ((low_space_lock & LOW_ABS) == LOW_ABS &&
    (mid_space_lock & MID_ABS) == MID_ABS)
    else $error("absent sector unlocked");
  low_or_sec_a: assert property ((low_space_lock & $past(secondary_low_lock)) ==
    $past(secondary_low_lock))
    else $error("secondary low lock not merged");
  ts_or_sec_a: assert property ($past(secondary_test_shadow_lock) |-> test_shadow_prog_lock)
    else $error("secondary test lock not merged");
  nv_addr_a: assert property (nv_addr == NV_DEFAULT_ADDR)
    else $error("wrong default word address");
  nv_req_hold_a: assert property (nv_rd_req && !nv_rd_valid |=> nv_rd_req)
    else $error("default word request dropped");
endmodule

// [bench/tb_top.sv]
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import dllk_pkg::*;
  logic sys_clk = 1'b0, arst_n = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0, nv_rd_data = 32'h0, wb_dat_o, rnd = 32'h00000032, e, q;
  logic [3:0] wb_sel_i = 4'h0;
  logic secondary_test_shadow_lock = 1'b0, interlock_write = 1'b0, done_flag = 1'b0;
  logic erase_suspend_flag = 1'b0, nv_rd_valid = 1'b0;
  logic [15:0] secondary_low_lock = 16'h0, low_space_lock;
  logic [1:0] secondary_mid_lock = 2'h0, mid_space_lock;
  logic wb_ack_o, nv_rd_req, lock_edit_enable, test_shadow_prog_lock, test_shadow_erase_lock;
  logic [23:0] nv_addr;
  int fails = 0, samples_checked = 0;
  dllk_lock dllk_lock_i (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i),
    .wb_sel_i(wb_sel_i),
    .wb_ack_o(wb_ack_o),
    .wb_dat_o(wb_dat_o),
    .secondary_test_shadow_lock(secondary_test_shadow_lock),
    .secondary_low_lock(secondary_low_lock),
    .secondary_mid_lock(secondary_mid_lock),
    .interlock_write(interlock_write),
    .done_flag(done_flag),
    .erase_suspend_flag(erase_suspend_flag),
    .nv_rd_req(nv_rd_req),
    .nv_addr(nv_addr),
    .nv_rd_valid(nv_rd_valid),
    .nv_rd_data(nv_rd_data),
    .lock_edit_enable(lock_edit_enable),
    .test_shadow_prog_lock(test_shadow_prog_lock),
    .test_shadow_erase_lock(test_shadow_erase_lock),
    .low_space_lock(low_space_lock),
    .mid_space_lock(mid_space_lock)
  );
  always #20 sys_clk = ~sys_clk;
  ////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // only test/shadow and the four present low bits are writable
  function automatic logic [31:0] wr(input logic [31:0] x, d, input logic [3:0] s, input logic f);
    logic [31:0] m;
    m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}} & 32'h0010000F;
    if (f) m = 32'h0;
    if (!x[31]) return (d == LML_PASSWORD && s == 4'hF) ? (x | 32'h80000000) : x;
    return (x & ~m) | (d & m);
  endfunction
  task automatic final_report;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, x);
    samples_checked++;
    if (g !== x) begin
      fails++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, x);
    end
  endtask
  // no cycle count assumed: wait for ack under a bound
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s, output logic [31:0] r);
    int n;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= s;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) begin
      fails++;
      final_report();
    end
    r = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] x);
    bus(1'b0, a, 32'h0, 4'hF, q);
    chk(q, x);
  endtask
  task automatic w4(input logic [31:0] d, input logic [3:0] s, input logic f);
    bus(1'b1, LML_OFFSET, d, s, q);
    e = wr(e, d, s, f);
  endtask
  task automatic outs;
    repeat (3) @(posedge sys_clk);
    chk({lock_edit_enable, test_shadow_prog_lock, test_shadow_erase_lock,
      mid_space_lock, low_space_lock}, {e[31], e[20] | secondary_test_shadow_lock, 1'b1,
      e[17:16] | secondary_mid_lock, e[15:0] | secondary_low_lock});
  endtask
  task automatic rst(input logic [31:0] w);
    int n;
    arst_n <= 1'b0;
    repeat (12) @(posedge sys_clk);
    arst_n <= 1'b1;
    n = 0;
    while (nv_rd_req !== 1'b1 && n < 20) begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= 20) begin
      fails++;
      final_report();
    end
    nv_rd_valid <= 1'b1;
    nv_rd_data <= w;
    @(posedge sys_clk);
    nv_rd_valid <= 1'b0;
    nv_rd_data <= ~w;
    repeat (3) @(posedge sys_clk);
    e = 32'h0003FFF0 | (w & 32'h0010000F);
  endtask
  ////////////////////////////////////////
  initial begin
    rst(32'hFFFFFFFF);
    rd_chk(LML_OFFSET, 32'h0013FFFF);
    rd_chk(LML_STATUS_OFFSET, 32'h00000001);
    outs();
    rnd = lfsr(rnd);
    w4(rnd & 32'h7FEFFFF0, 4'hF, 1'b0);
    rd_chk(LML_OFFSET, e);
    w4(LML_PASSWORD, 4'h7, 1'b0);
    rd_chk(LML_OFFSET, e);
    rnd = lfsr(rnd);
    rst(rnd);
    rd_chk(LML_OFFSET, e);
    w4(LML_PASSWORD, 4'hF, 1'b0);
    rd_chk(LML_OFFSET, e);
    for (int i = 0; i < 24; i++) begin
      rnd = lfsr(rnd);
      {secondary_test_shadow_lock, secondary_mid_lock, secondary_low_lock} <= rnd[18:0];
      w4((i == 3) ? LML_PASSWORD : lfsr(rnd), rnd[31:28], 1'b0);
      rd_chk(LML_OFFSET, e);
      outs();
    end
    bus(1'b1, 8'h0C, 32'h0, 4'hF, q);
    rd_chk(8'h0C, 32'h0);
    rd_chk(LML_OFFSET, e);
    interlock_write <= 1'b1;
    @(posedge sys_clk);
    interlock_write <= 1'b0;
    w4(~e, 4'hF, 1'b1);
    rd_chk(LML_OFFSET, e);
    rd_chk(LML_STATUS_OFFSET, 32'h0000000B);
    done_flag <= 1'b1;
    repeat (2) @(posedge sys_clk);
    w4(~e, 4'hF, 1'b0);
    rd_chk(LML_OFFSET, e);
    erase_suspend_flag <= 1'b1;
    @(posedge sys_clk);
    w4(~e, 4'hF, 1'b1);
    rd_chk(LML_OFFSET, e);
    rd_chk(LML_STATUS_OFFSET, 32'h0000000D);
    done_flag <= 1'b0;
    @(posedge sys_clk);
    w4(~e, 4'hF, 1'b0);
    rd_chk(LML_OFFSET, e);
    outs();
    final_report();
  end
endmodule

bind dllk_lock dllk_lock_chk #(
  .ADDR_W(ADDR_W),
  .LOW_SECTORS(LOW_SECTORS),
  .MID_SECTORS(MID_SECTORS)
) dllk_lock_chk_i (
  .sys_clk(sys_clk),
  .arst_n(arst_n),
  .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i),
  .wb_dat_i(wb_dat_i),
  .wb_sel_i(wb_sel_i),
  .wb_ack_o(wb_ack_o),
  .wb_dat_o(wb_dat_o),
  .secondary_test_shadow_lock(secondary_test_shadow_lock),
  .secondary_low_lock(secondary_low_lock),
  .nv_rd_req(nv_rd_req),
  .nv_addr(nv_addr),
  .nv_rd_valid(nv_rd_valid),
  .lock_edit_enable(lock_edit_enable),
  .test_shadow_prog_lock(test_shadow_prog_lock),
  .test_shadow_erase_lock(test_shadow_erase_lock),
  .low_space_lock(low_space_lock),
  .mid_space_lock(mid_space_lock)
);
